// ---- hdl/ulc_pkg.sv ----
package ulc_pkg;

  localparam int ULC_W = 8;
  localparam int ULC_PLA_IN = 12;
  localparam int ULC_PLA_TERMS = 8;
  localparam int ULC_PLA_OUT = 4;
  localparam int ULC_CFG_WORDS = 8;
  localparam int ULC_FIFO_DEPTH = 4;

  // Word offsets on the register port, all indices of 16-bit words
  localparam logic [3:0] ULC_ADDR_ACC0 = 4'h0;
  localparam logic [3:0] ULC_ADDR_ACC1 = 4'h1;
  localparam logic [3:0] ULC_ADDR_DAT0 = 4'h2;
  localparam logic [3:0] ULC_ADDR_DAT1 = 4'h3;
  localparam logic [3:0] ULC_ADDR_FIFO0 = 4'h4;
  localparam logic [3:0] ULC_ADDR_FIFO1 = 4'h5;
  localparam logic [3:0] ULC_ADDR_CFG_BASE = 4'h8;

  localparam logic [7:0] ULC_REG_RESET = 8'h00;
  localparam logic [15:0] ULC_CFG_RESET = 16'h0000;

  // Condition codes selectable onto the six routing outputs
  localparam logic [3:0] ULC_COND_CMP0_EQ = 4'h0;
  localparam logic [3:0] ULC_COND_CMP0_LT = 4'h1;
  localparam logic [3:0] ULC_COND_CMP1_EQ = 4'h2;
  localparam logic [3:0] ULC_COND_CMP1_LT = 4'h3;
  localparam logic [3:0] ULC_COND_ZERO0 = 4'h4;
  localparam logic [3:0] ULC_COND_ZERO1 = 4'h5;
  localparam logic [3:0] ULC_COND_ONES0 = 4'h6;
  localparam logic [3:0] ULC_COND_ONES1 = 4'h7;
  localparam logic [3:0] ULC_COND_OVF = 4'h8;
  localparam logic [3:0] ULC_COND_SOUT = 4'h9;
  localparam logic [3:0] ULC_COND_F0_EMPTY = 4'ha;
  localparam logic [3:0] ULC_COND_F0_FULL = 4'hb;
  localparam logic [3:0] ULC_COND_F1_EMPTY = 4'hc;
  localparam logic [3:0] ULC_COND_F1_FULL = 4'hd;
  localparam logic [3:0] ULC_COND_BOTH_EQ = 4'he;
  localparam logic [3:0] ULC_COND_CHAIN_EQ = 4'hf;

  typedef enum logic [2:0] {
    ULC_OP_PASS = 3'b000,
    ULC_OP_INC = 3'b001,
    ULC_OP_DEC = 3'b010,
    ULC_OP_ADD = 3'b011,
    ULC_OP_SUB = 3'b100,
    ULC_OP_AND = 3'b101,
    ULC_OP_OR = 3'b110,
    ULC_OP_XOR = 3'b111
  } ulc_alu_op_t;

  typedef enum logic [1:0] {
    ULC_SH_NONE = 2'b00,
    ULC_SH_LEFT = 2'b01,
    ULC_SH_RIGHT = 2'b10,
    ULC_SH_SWAP = 2'b11
  } ulc_shift_t;

  // One 16-bit dynamic configuration word
  typedef struct packed {
    ulc_alu_op_t alu_op;
    logic src_a;
    logic [1:0] src_b;
    ulc_shift_t shift;
    logic [1:0] dst;
    logic mask_en;
    logic crc_en;
    logic fifo_load;
    logic [1:0] fifo_wr;
    logic fifo_src;
  } ulc_cfg_t;

  // Link to a neighbouring cell
  typedef struct packed {
    logic carry;
    logic shift;
    logic eq;
    logic lt;
  } ulc_chain_t;

endpackage : ulc_pkg

// ---- hdl/ulc_top.sv ----
// Overview of operation
// - Each array: twelve inputs, eight shared terms
// - Product term ANDs one to twelve inputs
// - Each term input picks true or inverted
// - Each output ORs up to eight terms
// - Array outputs registered or combinational per bit
// - Two arrays beside one datapath
// - Eight-bit datapath, single-cycle arithmetic unit
// - Four working registers readable and writable
// - Accumulators: operands, results and compare inputs
// - Data registers are operands, never results
// - Queues load registers or capture results
// - Each queue holds four bytes
// - Eight sixteen-bit words select per-cycle function
// - Eight operations: inc, dec, add, sub, logic, pass
// - Shift left, right, swap, OR mask
// - Two masked compares over selectable operands
// - Zero, ones, overflow; conditions selectable outward
// - Compare chaining through neighbour links
// - Programmable most significant bit position
// - One CRC or sequence step per cycle
// - Wider CRC extends through chained neighbours
// - Queue direction: input or output buffer
// - Six routing inputs and six outputs
// - Queue status selectable as outputs
`timescale 1ns/10ps
module ulc_top #(
  parameter int FIFO_DEPTH = ulc_pkg::ULC_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  input wire logic [1:0][11:0] pla_in,
  input wire logic [1:0][7:0][11:0] pla_true_sel,
  input wire logic [1:0][7:0][11:0] pla_comp_sel,
  input wire logic [1:0][3:0][7:0] pla_sum_sel,
  input wire logic [1:0][3:0] pla_reg_sel,
  output logic [1:0][3:0] pla_out,
  input wire logic [5:0] dp_in,
  output logic [5:0] dp_out,
  input wire logic [5:0][3:0] out_sel,
  input wire logic [1:0][7:0] cmp_mask,
  input wire logic [1:0][1:0] cmp_sel,
  input wire logic [2:0] msb_pos,
  input wire logic [7:0] alu_mask,
  input wire logic [7:0] crc_poly,
  input wire logic chain_en,
  input wire logic [1:0] fifo_dir,
  input wire ulc_pkg::ulc_chain_t chain_in,
  output ulc_pkg::ulc_chain_t chain_out
);

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  logic [1:0] rst_pipe;
  logic rst_n;
  logic [1:0][7:0] pterm;
  logic [1:0][3:0] psum;
  logic [1:0][3:0] pla_q;
  logic [15:0] cfg_ram [ulc_pkg::ULC_CFG_WORDS];
  ulc_pkg::ulc_cfg_t cfg;
  logic run;
  logic [7:0] acc0, acc1, dat0, dat1;
  logic [7:0] op_a, op_b, msb_mask, msb_bit, shifted, result, crc_next;
  logic [8:0] alu9;
  logic sin, sout, carry, fb, carry_q, sout_q;
  logic [7:0] fifo_mem [2][FIFO_DEPTH];
  logic [PW-1:0] fifo_wp [2];
  logic [PW-1:0] fifo_rp [2];
  logic [CW-1:0] fifo_cnt [2];
  logic [7:0] fifo_head [2];
  logic [7:0] fifo_din [2];
  logic [1:0] fifo_push, fifo_pop, fifo_full, fifo_empty;
  logic [1:0] cmp_eq, cmp_lt;
  logic [15:0] cond;

  // Async assert, release through two stages
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // Two arrays; a term ignores inputs with neither polarity enabled
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      for (int t = 0; t < ulc_pkg::ULC_PLA_TERMS; t++) begin
        pterm[p][t] = &((pla_in[p] | ~pla_true_sel[p][t]) &
                        (~pla_in[p] | ~pla_comp_sel[p][t]));
      end
      for (int o = 0; o < ulc_pkg::ULC_PLA_OUT; o++) begin
        psum[p][o] = |(pterm[p] & pla_sum_sel[p][o]);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pla_q <= '0;
    end else begin
      pla_q <= psum;
    end
  end

  // Combinational outputs bypass the flop so logic equations stay zero-lag
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      for (int o = 0; o < ulc_pkg::ULC_PLA_OUT; o++) begin
        pla_out[p][o] = pla_reg_sel[p][o] ? pla_q[p][o] : psum[p][o];
      end
    end
  end

  // Address from routing picks this cycle's configuration
  assign cfg = ulc_pkg::ulc_cfg_t'(cfg_ram[dp_in[2:0]]);
  assign run = dp_in[5];
  assign sin = chain_en ? chain_in.shift : dp_in[3];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int w = 0; w < ulc_pkg::ULC_CFG_WORDS; w++) begin
        cfg_ram[w] <= ulc_pkg::ULC_CFG_RESET;
      end
    end else if (bus_wr && bus_addr[3]) begin
      cfg_ram[bus_addr[2:0]] <= bus_wdata;
    end
  end

  always_comb begin
    op_a = cfg.src_a ? acc1 : acc0;
    unique case (cfg.src_b)
      2'h0: op_b = dat0;
      2'h1: op_b = dat1;
      2'h2: op_b = acc0;
      2'h3: op_b = acc1;
    endcase
    msb_mask = 8'((9'h002 << msb_pos) - 9'h001);
    msb_bit = 8'h01 << msb_pos;
    unique case (cfg.alu_op)
      ulc_pkg::ULC_OP_PASS: alu9 = {1'b0, op_a};
      ulc_pkg::ULC_OP_INC: alu9 = {1'b0, op_a} + 9'h001;
      ulc_pkg::ULC_OP_DEC: alu9 = {1'b0, op_a} - 9'h001;
      ulc_pkg::ULC_OP_ADD: alu9 = {1'b0, op_a} + {1'b0, op_b} +
                                  {8'h00, chain_en & chain_in.carry};
      ulc_pkg::ULC_OP_SUB: alu9 = {1'b0, op_a} - {1'b0, op_b};
      ulc_pkg::ULC_OP_AND: alu9 = {1'b0, op_a & op_b};
      ulc_pkg::ULC_OP_OR: alu9 = {1'b0, op_a | op_b};
      ulc_pkg::ULC_OP_XOR: alu9 = {1'b0, op_a ^ op_b};
    endcase
    // Carry taken just above the programmed top bit
    carry = alu9[4'({1'b0, msb_pos}) + 4'h1];
    fb = op_a[msb_pos] ^ sin;
    crc_next = ({op_a[6:0], 1'b0} ^ (fb ? crc_poly : 8'h00)) & msb_mask;
    unique case (cfg.shift)
      ulc_pkg::ULC_SH_NONE: shifted = alu9[7:0];
      ulc_pkg::ULC_SH_LEFT: shifted = {alu9[6:0], sin};
      ulc_pkg::ULC_SH_RIGHT: shifted = ((alu9[7:0] & msb_mask) >> 1) |
                                       (sin ? msb_bit : 8'h00);
      ulc_pkg::ULC_SH_SWAP: shifted = {alu9[3:0], alu9[7:4]};
    endcase
    if (cfg.crc_en) begin
      sout = op_a[msb_pos];
    end else if (cfg.shift == ulc_pkg::ULC_SH_LEFT) begin
      sout = alu9[msb_pos];
    end else if (cfg.shift == ulc_pkg::ULC_SH_RIGHT) begin
      sout = alu9[0];
    end else begin
      sout = 1'b0;
    end
    if (cfg.crc_en) begin
      result = crc_next;
    end else begin
      result = (cfg.mask_en ? (shifted | alu_mask) : shifted) & msb_mask;
    end
  end

  // Queues: direction per queue, bus on one side, datapath on the other
  for (genvar q = 0; q < 2; q++) begin : g_fifo
    assign fifo_full[q] = fifo_cnt[q] == CW'(FIFO_DEPTH);
    assign fifo_empty[q] = fifo_cnt[q] == '0;
    assign fifo_head[q] = fifo_mem[q][fifo_rp[q]];
    assign fifo_din[q] = fifo_dir[q] ?
      (cfg.fifo_src ? result : (q == 0 ? acc0 : acc1)) : bus_wdata[7:0];
    // Full pushes and empty pops are dropped, contents untouched
    assign fifo_push[q] = !fifo_full[q] & (fifo_dir[q] ?
      (run & cfg.fifo_wr[q]) :
      (bus_wr & (bus_addr == ulc_pkg::ULC_ADDR_FIFO0 + 4'(q))));
    assign fifo_pop[q] = !fifo_empty[q] & (fifo_dir[q] ?
      (bus_rd & (bus_addr == ulc_pkg::ULC_ADDR_FIFO0 + 4'(q))) :
      (run & cfg.fifo_load));

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        fifo_wp[q] <= '0;
        fifo_rp[q] <= '0;
        fifo_cnt[q] <= '0;
        for (int e = 0; e < FIFO_DEPTH; e++) begin
          fifo_mem[q][e] <= ulc_pkg::ULC_REG_RESET;
        end
      end else begin
        if (fifo_push[q]) begin
          fifo_mem[q][fifo_wp[q]] <= fifo_din[q];
          fifo_wp[q] <= (fifo_wp[q] == PW'(FIFO_DEPTH - 1)) ? '0 :
                        fifo_wp[q] + PW'(1);
        end
        if (fifo_pop[q]) begin
          fifo_rp[q] <= (fifo_rp[q] == PW'(FIFO_DEPTH - 1)) ? '0 :
                        fifo_rp[q] + PW'(1);
        end
        if (fifo_push[q] && !fifo_pop[q]) begin
          fifo_cnt[q] <= fifo_cnt[q] + CW'(1);
        end else if (fifo_pop[q] && !fifo_push[q]) begin
          fifo_cnt[q] <= fifo_cnt[q] - CW'(1);
        end
      end
    end
  end

  // Bus writes win over the datapath in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc0 <= ulc_pkg::ULC_REG_RESET;
      acc1 <= ulc_pkg::ULC_REG_RESET;
    end else begin
      if (bus_wr && bus_addr == ulc_pkg::ULC_ADDR_ACC0) begin
        acc0 <= bus_wdata[7:0];
      end else if (run && cfg.dst[0]) begin
        if (!cfg.fifo_load) begin
          acc0 <= result;
        end else if (fifo_pop[0]) begin
          acc0 <= fifo_head[0];
        end
      end
      if (bus_wr && bus_addr == ulc_pkg::ULC_ADDR_ACC1) begin
        acc1 <= bus_wdata[7:0];
      end else if (run && cfg.dst[1]) begin
        if (!cfg.fifo_load) begin
          acc1 <= result;
        end else if (fifo_pop[1]) begin
          acc1 <= fifo_head[1];
        end
      end
    end
  end

  // Data registers never take the arithmetic result
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dat0 <= ulc_pkg::ULC_REG_RESET;
      dat1 <= ulc_pkg::ULC_REG_RESET;
    end else begin
      if (bus_wr && bus_addr == ulc_pkg::ULC_ADDR_DAT0) begin
        dat0 <= bus_wdata[7:0];
      end else if (run && cfg.fifo_load && !cfg.dst[0] && fifo_pop[0]) begin
        dat0 <= fifo_head[0];
      end
      if (bus_wr && bus_addr == ulc_pkg::ULC_ADDR_DAT1) begin
        dat1 <= bus_wdata[7:0];
      end else if (run && cfg.fifo_load && !cfg.dst[1] && fifo_pop[1]) begin
        dat1 <= fifo_head[1];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_q <= 1'b0;
      sout_q <= 1'b0;
    end else if (run) begin
      carry_q <= carry;
      sout_q <= sout;
    end
  end

  // Compare 0 chains toward the more significant neighbour
  always_comb begin
    logic [7:0] x, y;
    x = 8'h00;
    y = 8'h00;
    for (int c = 0; c < 2; c++) begin
      unique case (cmp_sel[c])
        2'h0: begin x = acc0; y = dat0; end
        2'h1: begin x = acc1; y = dat1; end
        2'h2: begin x = acc0; y = acc1; end
        2'h3: begin x = acc1; y = dat0; end
      endcase
      cmp_eq[c] = ((x ^ y) & cmp_mask[c]) == 8'h00;
      cmp_lt[c] = (x & cmp_mask[c]) < (y & cmp_mask[c]);
    end
    if (chain_en) begin
      cmp_lt[0] = cmp_lt[0] | (cmp_eq[0] & chain_in.lt);
      cmp_eq[0] = cmp_eq[0] & chain_in.eq;
    end
  end

  always_comb begin
    cond = '0;
    cond[ulc_pkg::ULC_COND_CMP0_EQ] = cmp_eq[0];
    cond[ulc_pkg::ULC_COND_CMP0_LT] = cmp_lt[0];
    cond[ulc_pkg::ULC_COND_CMP1_EQ] = cmp_eq[1];
    cond[ulc_pkg::ULC_COND_CMP1_LT] = cmp_lt[1];
    cond[ulc_pkg::ULC_COND_ZERO0] = (acc0 & msb_mask) == 8'h00;
    cond[ulc_pkg::ULC_COND_ZERO1] = (acc1 & msb_mask) == 8'h00;
    cond[ulc_pkg::ULC_COND_ONES0] = (acc0 | ~msb_mask) == 8'hff;
    cond[ulc_pkg::ULC_COND_ONES1] = (acc1 | ~msb_mask) == 8'hff;
    cond[ulc_pkg::ULC_COND_OVF] = carry_q;
    cond[ulc_pkg::ULC_COND_SOUT] = sout_q;
    cond[ulc_pkg::ULC_COND_F0_EMPTY] = fifo_empty[0];
    cond[ulc_pkg::ULC_COND_F0_FULL] = fifo_full[0];
    cond[ulc_pkg::ULC_COND_F1_EMPTY] = fifo_empty[1];
    cond[ulc_pkg::ULC_COND_F1_FULL] = fifo_full[1];
    cond[ulc_pkg::ULC_COND_BOTH_EQ] = cmp_eq[0] & cmp_eq[1];
    cond[ulc_pkg::ULC_COND_CHAIN_EQ] = chain_in.eq;
  end

  // Registered outputs add a cycle but keep routing glitch-free
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_out <= '0;
      chain_out <= '0;
    end else begin
      for (int k = 0; k < 6; k++) begin
        dp_out[k] <= cond[out_sel[k]];
      end
      chain_out <= '{carry: carry, shift: sout, eq: cmp_eq[0], lt: cmp_lt[0]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 16'h0000;
    end else if (bus_rd) begin
      if (bus_addr[3]) begin
        bus_rdata <= cfg_ram[bus_addr[2:0]];
      end else begin
        unique case (bus_addr)
          ulc_pkg::ULC_ADDR_ACC0: bus_rdata <= {8'h00, acc0};
          ulc_pkg::ULC_ADDR_ACC1: bus_rdata <= {8'h00, acc1};
          ulc_pkg::ULC_ADDR_DAT0: bus_rdata <= {8'h00, dat0};
          ulc_pkg::ULC_ADDR_DAT1: bus_rdata <= {8'h00, dat1};
          ulc_pkg::ULC_ADDR_FIFO0: bus_rdata <= {8'h00, fifo_head[0]};
          ulc_pkg::ULC_ADDR_FIFO1: bus_rdata <= {8'h00, fifo_head[1]};
          default: bus_rdata <= 16'h0000;
        endcase
      end
    end
  end

  a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
    fifo_cnt[0] <= CW'(FIFO_DEPTH) && fifo_cnt[1] <= CW'(FIFO_DEPTH))
    else $error("queue count above depth");

  a_full_write_held: assert property (@(posedge clk) disable iff (!rst_n)
    fifo_full[0] && !fifo_pop[0] |=> fifo_full[0] && $stable(fifo_wp[0]))
    else $error("write to full queue changed it");

  a_empty_read_held: assert property (@(posedge clk) disable iff (!rst_n)
    fifo_empty[1] && !fifo_push[1] |=> fifo_empty[1] && $stable(fifo_rp[1]))
    else $error("read from empty queue changed it");

  a_cfg_word_write: assert property (@(posedge clk) disable iff (!rst_n)
    bus_wr && bus_addr[3] |=> cfg_ram[$past(bus_addr[2:0])] == $past(bus_wdata))
    else $error("configuration word not stored");

  a_acc_readback: assert property (@(posedge clk) disable iff (!rst_n)
    bus_wr && bus_addr == ulc_pkg::ULC_ADDR_ACC1 ##1
    bus_rd && bus_addr == ulc_pkg::ULC_ADDR_ACC1 && !run
    |=> bus_rdata == {8'h00, $past(bus_wdata[7:0], 2)})
    else $error("accumulator readback mismatch");

  a_dat_no_result: assert property (@(posedge clk) disable iff (!rst_n)
    !bus_wr && !(run && cfg.fifo_load) |=> $stable(dat0) && $stable(dat1))
    else $error("data register changed without load");

  a_inc_step: assert property (@(posedge clk) disable iff (!rst_n)
    run && !bus_wr && cfg.alu_op == ulc_pkg::ULC_OP_INC && cfg.dst == 2'b01
    && !cfg.src_a && cfg.shift == ulc_pkg::ULC_SH_NONE && !cfg.mask_en
    && !cfg.crc_en && !cfg.fifo_load
    |=> acc0 == 8'(($past(acc0) + 8'h01) & $past(msb_mask)))
    else $error("increment result wrong");

  a_zero_out: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && out_sel[1] == ulc_pkg::ULC_COND_ZERO0 && msb_pos == 3'h7
    |=> dp_out[1] == ($past(acc0) == 8'h00))
    else $error("zero detect output wrong");

  a_pla_comb: assert property (@(posedge clk) disable iff (!rst_n)
    !pla_reg_sel[0][0] |-> pla_out[0][0] == |(pterm[0] & pla_sum_sel[0][0]))
    else $error("combinational array output wrong");

  a_pla_reg: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 pla_reg_sel[1][1] |-> pla_out[1][1] == $past(psum[1][1]))
    else $error("registered array output wrong");

endmodule : ulc_top

// ---- testbench/test_programmable_logic_datapath_cell.sv ----
`timescale 1ns/10ps
module test_programmable_logic_datapath_cell;
  logic clk, reset_n, bus_wr, bus_rd, chain_en, run, sin, e;
  logic [3:0] bus_addr;
  logic [15:0] bus_wdata, bus_rdata, rd;
  logic [1:0][11:0] pla_in;
  logic [1:0][7:0][11:0] pla_true_sel, pla_comp_sel;
  logic [1:0][3:0][7:0] pla_sum_sel;
  logic [1:0][3:0] pla_reg_sel, pla_out;
  logic [5:0] dp_in, dp_out;
  logic [5:0][3:0] out_sel;
  logic [1:0][7:0] cmp_mask;
  logic [1:0][1:0] cmp_sel;
  logic [2:0] msb_pos, dpa;
  logic [7:0] alu_mask, crc_poly, rnd, a, b, v;
  logic [1:0] fifo_dir;
  logic [7:0] q[$];
  ulc_pkg::ulc_chain_t chain_in, chain_out;
  int miscompares, n_checks;

  ulc_top dut (.clk, .reset_n, .bus_addr, .bus_wr, .bus_rd, .bus_wdata,
    .bus_rdata, .pla_in, .pla_true_sel, .pla_comp_sel, .pla_sum_sel,
    .pla_reg_sel, .pla_out, .dp_in, .dp_out, .out_sel, .cmp_mask,
    .cmp_sel, .msb_pos, .alu_mask, .crc_poly, .chain_en, .fifo_dir,
    .chain_in, .chain_out);
  ulc_route_model route (.clk, .run, .cfg_addr(dpa), .sin, .dp_in);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [7:0] nxt();
    rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
    return rnd;
  endfunction : nxt

  function automatic logic [15:0] cw(int op, int sh, int dst, int mk,
                                     int fl, int fw, int fs);
    return {3'(op), 3'h0, 2'(sh), 2'(dst), 1'(mk), 1'b0, 1'(fl),
            2'(fw), 1'(fs)};
  endfunction : cw

  // Reference arithmetic unit, shifter, mask and msb clip
  function automatic logic [7:0] alu(int op, int x, int y, int sh,
                                     int mk);
    int r;
    int m;
    m = (2 << msb_pos) - 1;
    case (op)
      0: r = x;
      1: r = x + 1;
      2: r = x - 1;
      3: r = x + y;
      4: r = x - y;
      5: r = x & y;
      6: r = x | y;
      default: r = x ^ y;
    endcase
    if (sh == 1) r = r << 1;
    if (sh == 2) r = (r & m) >> 1;
    if (sh == 3) r = ((r & 15) << 4) | ((r >> 4) & 15);
    if (mk != 0) r = r | alu_mask;
    return 8'(r & m);
  endfunction : alu

  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic bw(input logic [3:0] ad, input logic [15:0] d);
    @(negedge clk);
    bus_addr = ad;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge clk);
    bus_wr = 1'b0;
  endtask : bw

  // Data is taken one full cycle after the strobe edge
  task automatic br(input logic [3:0] ad, output logic [15:0] d);
    bus_addr = ad;
    bus_rd = 1'b1;
    @(negedge clk);
    bus_rd = 1'b0;
    @(negedge clk);
    d = bus_rdata;
  endtask : br

  task automatic step(input logic [2:0] ad);
    @(negedge clk);
    dpa = ad;
    run = 1'b1;
    @(negedge clk);
    run = 1'b0;
  endtask : step

  task automatic finish_test();
    $display("n_checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    #40000;
    miscompares++;
    finish_test();
  end

  initial begin
    rnd = 8'h1d;
    reset_n = 1'b0;
    {bus_wr, bus_rd, chain_en, run, sin} = '0;
    bus_addr = '0;
    bus_wdata = '0;
    pla_in = '0;
    dpa = '0;
    chain_in = '0;
    crc_poly = 8'h07;
    alu_mask = 8'h00;
    msb_pos = 3'h7;
    fifo_dir = 2'h0;
    cmp_sel = '0;
    cmp_mask = {8'hff, 8'hf0};
    out_sel = {ulc_pkg::ULC_COND_CMP0_LT, ulc_pkg::ULC_COND_ONES0,
      ulc_pkg::ULC_COND_F0_EMPTY, ulc_pkg::ULC_COND_F0_FULL,
      ulc_pkg::ULC_COND_ZERO0, ulc_pkg::ULC_COND_CMP0_EQ};
    pla_true_sel = '0;
    pla_comp_sel = '0;
    pla_sum_sel = '0;
    pla_true_sel[0][0] = 12'h001;
    pla_comp_sel[0][0] = 12'h002;
    pla_true_sel[0][1] = 12'h00c;
    pla_sum_sel[0][0] = 8'h03;
    pla_sum_sel[0][1] = 8'h02;
    pla_reg_sel = {4'h2, 4'h2};
    pla_true_sel[1] = pla_true_sel[0];
    pla_comp_sel[1] = pla_comp_sel[0];
    pla_sum_sel[1] = pla_sum_sel[0];
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    check("f0_empty", dp_out[3], 1'b1);
    for (int i = 0; i < 7; i++) begin
      br(4'(i), rd);
      check("reset_read", rd, 16'h0000);
    end
    for (int i = 0; i < 4; i++) begin
      v = nxt();
      bw(4'(i), {8'hff, v});
      br(4'(i), rd);
      check("reg_rw", rd, {8'h00, v});
    end
    bw(4'h6, 16'hffff);
    br(4'h6, rd);
    check("unmapped", rd, 16'h0000);
    // Each operation sits in its own config word
    for (int op = 0; op < 8; op++) begin
      a = nxt();
      b = nxt();
      bw(4'h0, {8'h00, a});
      bw(4'h2, {8'h00, b});
      bw({1'b1, 3'(op)}, cw(op, 0, 1, 0, 0, 0, 0));
      step(3'(op));
      br(4'h0, rd);
      check("alu_acc0", rd, {8'h00, alu(op, a, b, 0, 0)});
      br(4'h2, rd);
      check("dat0_kept", rd, {8'h00, b});
    end
    for (int sh = 0; sh < 4; sh++) begin
      a = nxt();
      alu_mask = nxt();
      bw(4'h0, {8'h00, a});
      bw(4'h8, cw(0, sh, 1, sh == 0, 0, 0, 0));
      step(3'h0);
      br(4'h0, rd);
      check("shift_mask", rd, {8'h00, alu(0, a, 0, sh, sh == 0)});
    end
    msb_pos = 3'h3;
    for (int i = 0; i < 2; i++) begin
      a = i ? 8'h0e : 8'h0f;
      bw(4'h0, {8'h00, a});
      step(3'h1);
      br(4'h0, rd);
      v = alu(1, a, 0, 0, 0);
      check("msb_inc", rd, {8'h00, v});
      check("zero0", dp_out[1], v == 8'h00);
      check("ones0", dp_out[4], v == 8'h0f);
    end
    msb_pos = 3'h7;
    for (int i = 0; i < 8; i++) begin
      a = nxt();
      b = i[0] ? a ^ (nxt() & 8'h0f) : nxt();
      chain_en = i[1];
      chain_in = 4'(nxt());
      bw(4'h0, {8'h00, a});
      bw(4'h2, {8'h00, b});
      repeat (2) @(negedge clk);
      e = (a & 8'hf0) == (b & 8'hf0);
      check("cmp0_lt", dp_out[5], ((a & 8'hf0) < (b & 8'hf0)) |
            (chain_en & e & chain_in.lt));
      check("cmp0_eq", dp_out[0], e & (!chain_en | chain_in.eq));
    end
    chain_en = 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      pla_in = {4'h0, nxt(), 4'h0, nxt()};
      #1;
      for (int k = 0; k < 2; k++) begin
        v = pla_in[k][7:0];
        check("pla_comb", pla_out[k][0],
              (v[0] & ~v[1]) | (v[2] & v[3]));
      end
      @(negedge clk);
      for (int k = 0; k < 2; k++) begin
        v = pla_in[k][7:0];
        check("pla_reg", pla_out[k][1], v[2] & v[3]);
      end
    end
    // Fifth write lands on a full queue and must be dropped
    for (int i = 0; i < 5; i++) begin
      v = nxt();
      bw(4'h4, {8'h00, v});
      if (q.size() < 4) q.push_back(v);
    end
    repeat (2) @(negedge clk);
    check("f0_full", dp_out[2], 1'b1);
    bw(4'hb, cw(0, 0, 0, 0, 1, 0, 0));
    for (int i = 0; i < 4; i++) begin
      step(3'h3);
      br(4'h2, rd);
      check("f0_to_dat0", rd, {8'h00, q.pop_front()});
    end
    repeat (2) @(negedge clk);
    check("f0_empty", dp_out[3], 1'b1);
    fifo_dir = 2'h2;
    a = nxt();
    bw(4'h0, {8'h00, a});
    bw(4'ha, cw(1, 0, 1, 0, 0, 2, 1));
    for (int i = 0; i < 3; i++) begin
      step(3'h2);
      a = a + 8'h01;
      q.push_back(a);
    end
    for (int i = 0; i < 3; i++) begin
      br(4'h5, rd);
      check("f1_out", rd, {8'h00, q.pop_front()});
    end
    crc_poly = nxt();
    a = nxt();
    bw(4'h0, {8'h00, a});
    // Word 4 runs one CRC step into acc0; bit 4 is the CRC enable
    bw(4'hc, cw(0, 0, 1, 0, 0, 0, 0) | 16'h0010);
    for (int i = 0; i < 8; i++) begin
      v = nxt();
      chain_en = i[0];
      sin = v[0];
      chain_in = 4'(v[7:4]);
      e = a[7] ^ (chain_en ? chain_in.shift : sin);
      a = {a[6:0], 1'b0} ^ (e ? crc_poly : 8'h00);
      step(3'h4);
      br(4'h0, rd);
      check("crc_step", rd, {8'h00, a});
      check("chain_shift", chain_out.shift, a[7]);
    end
    finish_test();
  end
endmodule : test_programmable_logic_datapath_cell

// ---- testbench/ulc_route_model.sv ----
`timescale 1ns/10ps
// Routing side: supplies the per-cycle config address, run and serial in
module ulc_route_model (
  input wire logic clk,
  input wire logic run,
  input wire logic [2:0] cfg_addr,
  input wire logic sin,
  output logic [5:0] dp_in
);
  logic spare;
  // Unused input never holds still, so the design cannot lean on it
  initial spare = 1'b0;
  always @(negedge clk) begin
    spare <= ~spare;
  end
  assign dp_in = {run, spare, sin, cfg_addr};
endmodule : ulc_route_model
